//--- design/rstc_top.sv
// Radio state transition configuration: registers, rx timeout, clear channel, next state.
// Assumes radio inputs come from same-clock logic and ref_tick pulses once per reference period.
//
// What this block does
// RL1: With signal-strength termination set, end reception when carrier sense drops while sync is not found.
// RL2: At timeout keep receiving on sync found, or on preamble quality if checked.
// RL3: Three-bit code bounds sync search time; code 111 disables the timeout.
// RL4: Timeout equals event period times C times 26 over reference MHz.
// RL5: Two-bit policy, reset 11, chooses how the channel-clear flag is formed.
// RL6: After receive go to state from post-receive field, reset 00.
// RL7: Software must not pair post-receive transmit or synth-ready with channel assessment.
// RL8: After transmit go to state from post-transmit field, reset 00.
// RL9: Timeout counter starts on entering receive and clears when reception ends.
// RL10: Unused register bits read zero and ignore writes.
`default_nettype none
module rstc_top (
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    // AXI4-Lite write address, data and response
    input wire logic [31:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read
    input wire logic [31:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Radio state machine side
    input wire rstc_pkg::rstc_radio_in_t RADIO_IN,
    output logic RX_TIMEOUT_OUT,
    output logic RX_TERMINATE_OUT,
    output logic CHANNEL_CLEAR_FLAG_OUT,
    output rstc_pkg::rstc_radio_state_t NEXT_STATE_OUT,
    output logic NEXT_STATE_VALID_OUT
);
    import rstc_pkg::*;

    logic aw_ready_q, w_ready_q, b_valid_q, ar_ready_q, r_valid_q;
    logic [31:0] aw_addr_q, w_data_q, r_data_q;
    logic [3:0] w_strb_q;
    logic [1:0] b_resp_q, r_resp_q;
    logic end_on_strength_q, quality_check_q;
    logic [2:0] timeout_code_q;
    logic [1:0] clear_policy_q, after_rx_q, after_tx_q;
    logic [31:0] ticks_q;
    logic timeout_done_q, terminate_done_q;
    logic rx_timeout_q, rx_terminate_q, channel_clear_q, next_valid_q;
    rstc_radio_state_t next_state_q;
    logic do_write, conflict;
    logic [31:0] target;
    logic [39:0] scaled;
    logic expire, strength_end, keep_rx;

    // Write channels taken in either order, response once both are held
    assign do_write = !aw_ready_q && !w_ready_q && !b_valid_q;
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            aw_ready_q <= 1'b1;
            w_ready_q <= 1'b1;
            b_valid_q <= 1'b0;
            b_resp_q <= RSTC_RESP_OKAY;
            aw_addr_q <= 32'h0000_0000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_ready_q && S_AXI_AWVALID_IN) begin
                aw_ready_q <= 1'b0;
                aw_addr_q <= S_AXI_AWADDR_IN;
            end
            if (w_ready_q && S_AXI_WVALID_IN) begin
                w_ready_q <= 1'b0;
                w_data_q <= S_AXI_WDATA_IN;
                w_strb_q <= S_AXI_WSTRB_IN;
            end
            if (do_write) begin
                b_valid_q <= 1'b1;
                if (aw_addr_q == RSTC_ADDR_RX_TIMEOUT_CONTROL || aw_addr_q == RSTC_ADDR_PACKET_END_STATE_CONTROL
                    || aw_addr_q == RSTC_ADDR_STATUS) begin
                    b_resp_q <= RSTC_RESP_OKAY;
                end else begin
                    b_resp_q <= RSTC_RESP_SLVERR;
                end
            end else if (b_valid_q && S_AXI_BREADY_IN) begin
                b_valid_q <= 1'b0;
                aw_ready_q <= 1'b1;
                w_ready_q <= 1'b1;
            end
        end
    end

    // Register writes; only byte lane 0 carries fields
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            end_on_strength_q <= RSTC_RST_RX_END_ON_SIGNAL_STRENGTH;
            quality_check_q <= RSTC_RST_RX_TIMEOUT_QUALITY_CHECK;
            timeout_code_q <= RSTC_RST_RX_TIMEOUT_CODE;
            clear_policy_q <= RSTC_RST_CLEAR_CHANNEL_POLICY; // [RL5]
            after_rx_q <= RSTC_RST_AFTER_RECEIVE_NEXT_STATE; // [RL6]
            after_tx_q <= RSTC_RST_AFTER_TRANSMIT_NEXT_STATE; // [RL8]
        end else if (do_write && w_strb_q[0]) begin
            // Unused bits are simply not stored [RL10]
            if (aw_addr_q == RSTC_ADDR_RX_TIMEOUT_CONTROL) begin
                end_on_strength_q <= w_data_q[RSTC_POS_RX_END_ON_SIGNAL_STRENGTH];
                quality_check_q <= w_data_q[RSTC_POS_RX_TIMEOUT_QUALITY_CHECK];
                timeout_code_q <= w_data_q[RSTC_POS_RX_TIMEOUT_CODE +: 3];
            end else if (aw_addr_q == RSTC_ADDR_PACKET_END_STATE_CONTROL) begin
                clear_policy_q <= w_data_q[RSTC_POS_CLEAR_CHANNEL_POLICY +: 2];
                after_rx_q <= w_data_q[RSTC_POS_AFTER_RECEIVE_NEXT_STATE +: 2];
                after_tx_q <= w_data_q[RSTC_POS_AFTER_TRANSMIT_NEXT_STATE +: 2];
            end
        end
    end

    // Post-receive move to tx or synth-ready while assessment is on is unsupported
    assign conflict = (after_rx_q == 2'h1 || after_rx_q == 2'h2) && clear_policy_q != 2'h0; // [RL7]

    // Read channel, answer one cycle after the address is taken
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ar_ready_q <= 1'b1;
            r_valid_q <= 1'b0;
            r_data_q <= 32'h0000_0000;
            r_resp_q <= RSTC_RESP_OKAY;
        end else if (ar_ready_q && S_AXI_ARVALID_IN) begin
            ar_ready_q <= 1'b0;
            r_valid_q <= 1'b1;
            r_data_q <= 32'h0000_0000; // [RL10]
            r_resp_q <= RSTC_RESP_OKAY;
            if (S_AXI_ARADDR_IN == RSTC_ADDR_RX_TIMEOUT_CONTROL) begin
                r_data_q[RSTC_POS_RX_END_ON_SIGNAL_STRENGTH] <= end_on_strength_q;
                r_data_q[RSTC_POS_RX_TIMEOUT_QUALITY_CHECK] <= quality_check_q;
                r_data_q[RSTC_POS_RX_TIMEOUT_CODE +: 3] <= timeout_code_q;
            end else if (S_AXI_ARADDR_IN == RSTC_ADDR_PACKET_END_STATE_CONTROL) begin
                r_data_q[RSTC_POS_CLEAR_CHANNEL_POLICY +: 2] <= clear_policy_q;
                r_data_q[RSTC_POS_AFTER_RECEIVE_NEXT_STATE +: 2] <= after_rx_q;
                r_data_q[RSTC_POS_AFTER_TRANSMIT_NEXT_STATE +: 2] <= after_tx_q;
            end else if (S_AXI_ARADDR_IN == RSTC_ADDR_STATUS) begin
                r_data_q[RSTC_POS_ST_TIMER_RUNNING] <= RADIO_IN.rx_active && timeout_code_q != RSTC_TIMEOUT_CODE_DISABLED;
                r_data_q[RSTC_POS_ST_TIMEOUT_SEEN] <= timeout_done_q;
                r_data_q[RSTC_POS_ST_CHANNEL_CLEAR] <= channel_clear_q;
                r_data_q[RSTC_POS_ST_CONFIG_CONFLICT] <= conflict;
            end else begin
                r_resp_q <= RSTC_RESP_SLVERR;
            end
        end else if (r_valid_q && S_AXI_RREADY_IN) begin
            r_valid_q <= 1'b0;
            ar_ready_q <= 1'b1;
        end
    end

    // Timeout target in quarter reference periods, scaled by 2^code
    // Every factor widened first so the product never wraps at the event width
    assign target = 32'(RADIO_IN.wake_event_period) * 32'({RADIO_IN.wake_resolution_select, 2'h1})
        * 32'(RSTC_TIMEOUT_SCALE_NUM); // [RL4]
    assign scaled = ({8'h00, ticks_q} << RSTC_TIMEOUT_SCALE_SHIFT) << timeout_code_q; // [RL4]
    assign expire = RADIO_IN.rx_active && !timeout_done_q && timeout_code_q != RSTC_TIMEOUT_CODE_DISABLED
        && scaled >= {8'h00, target}; // [RL3]
    assign keep_rx = RADIO_IN.sync_found || (quality_check_q && RADIO_IN.preamble_quality_reached); // [RL2]
    assign strength_end = end_on_strength_q && RADIO_IN.rx_active && !RADIO_IN.carrier_sense
        && !RADIO_IN.sync_found; // [RL1]

    // Reference period counter, alive only during reception
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ticks_q <= 32'h0000_0000;
        end else if (!RADIO_IN.rx_active) begin
            ticks_q <= 32'h0000_0000; // [RL9]
        end else if (RADIO_IN.ref_tick && ticks_q != 32'hffff_ffff) begin
            ticks_q <= ticks_q + 32'h0000_0001; // [RL9]
        end
    end

    // One expiry and one termination per receive period
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            timeout_done_q <= 1'b0;
            terminate_done_q <= 1'b0;
            rx_timeout_q <= 1'b0;
            rx_terminate_q <= 1'b0;
        end else begin
            rx_timeout_q <= expire;
            rx_terminate_q <= !terminate_done_q && ((expire && !keep_rx) || strength_end); // [RL2] [RL1]
            if (!RADIO_IN.rx_active) begin
                timeout_done_q <= 1'b0; // [RL9]
                terminate_done_q <= 1'b0;
            end else begin
                if (expire) begin
                    timeout_done_q <= 1'b1;
                end
                if ((expire && !keep_rx) || strength_end) begin
                    terminate_done_q <= 1'b1;
                end
            end
        end
    end

    // Channel clear flag from the selected policy
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            channel_clear_q <= 1'b0;
        end else begin
            case (clear_policy_q) // [RL5]
                2'h0: channel_clear_q <= 1'b1;
                2'h1: channel_clear_q <= !RADIO_IN.carrier_sense;
                2'h2: channel_clear_q <= !RADIO_IN.packet_receiving;
                default: channel_clear_q <= !RADIO_IN.carrier_sense && !RADIO_IN.packet_receiving;
            endcase
        end
    end

    // Next state after a packet; receive end wins if both come together
    always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            next_state_q <= RSTC_ST_IDLE;
            next_valid_q <= 1'b0;
        end else begin
            next_valid_q <= RADIO_IN.packet_received || RADIO_IN.packet_sent;
            if (RADIO_IN.packet_received) begin
                next_state_q <= rstc_radio_state_t'(after_rx_q); // [RL6]
            end else if (RADIO_IN.packet_sent) begin
                next_state_q <= rstc_radio_state_t'(after_tx_q); // [RL8]
            end
        end
    end

    assign S_AXI_AWREADY_OUT = aw_ready_q;
    assign S_AXI_WREADY_OUT = w_ready_q;
    assign S_AXI_BVALID_OUT = b_valid_q;
    assign S_AXI_BRESP_OUT = b_resp_q;
    assign S_AXI_ARREADY_OUT = ar_ready_q;
    assign S_AXI_RVALID_OUT = r_valid_q;
    assign S_AXI_RDATA_OUT = r_data_q;
    assign S_AXI_RRESP_OUT = r_resp_q;
    assign RX_TIMEOUT_OUT = rx_timeout_q;
    assign RX_TERMINATE_OUT = rx_terminate_q;
    assign CHANNEL_CLEAR_FLAG_OUT = channel_clear_q;
    assign NEXT_STATE_OUT = next_state_q;
    assign NEXT_STATE_VALID_OUT = next_valid_q;

    // Checks
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RESET_IN);
    a_strength_end: assert property (end_on_strength_q && RADIO_IN.rx_active && !RADIO_IN.carrier_sense
        && !RADIO_IN.sync_found && !terminate_done_q |=> RX_TERMINATE_OUT) else $error("no strength end"); // [RL1]
    a_timeout_keep: assert property (expire && keep_rx && !strength_end |=> !RX_TERMINATE_OUT)
        else $error("rx ended despite keep"); // [RL2]
    a_timeout_off: assert property (timeout_code_q == RSTC_TIMEOUT_CODE_DISABLED |=> !RX_TIMEOUT_OUT)
        else $error("timeout while disabled"); // [RL3]
    a_timeout_when: assert property (RX_TIMEOUT_OUT |-> $past(scaled) >= {8'h00, $past(target)}
        && $past(RADIO_IN.rx_active)) else $error("early timeout"); // [RL4]
    a_clear_policy: assert property (clear_policy_q == 2'h3 && RADIO_IN.carrier_sense ##1 1
        |-> !CHANNEL_CLEAR_FLAG_OUT) else $error("clear while busy"); // [RL5]
    a_rx_next: assert property (RADIO_IN.packet_received |=> NEXT_STATE_VALID_OUT
        && NEXT_STATE_OUT == $past(after_rx_q)) else $error("bad rx next state"); // [RL6]
    a_tx_next: assert property (RADIO_IN.packet_sent && !RADIO_IN.packet_received |=> NEXT_STATE_OUT
        == $past(after_tx_q)) else $error("bad tx next state"); // [RL8]
    a_timer_clear: assert property (!RADIO_IN.rx_active |=> ticks_q == 32'h0000_0000 && !timeout_done_q)
        else $error("timer not cleared"); // [RL9]
    a_unused_zero: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:6] == 26'h0000000)
        else $error("unused bits nonzero"); // [RL10]
    c_timeout_end: cover property (RX_TIMEOUT_OUT && RX_TERMINATE_OUT);
    c_timeout_kept: cover property (RX_TIMEOUT_OUT && !RX_TERMINATE_OUT);
    c_next_rx: cover property (NEXT_STATE_VALID_OUT && NEXT_STATE_OUT == RSTC_ST_RECEIVE);
    c_conflict: cover property (conflict);
endmodule : rstc_top
`default_nettype wire

//--- include/rstc_pkg.sv
// Package for the radio state transition configuration block.
// Assumes an AXI4-Lite master with 32-bit data on the system clock.
`default_nettype none
package rstc_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [15:0] RSTC_IDX_RX_TIMEOUT_CONTROL = 16'hdf12;
    localparam logic [15:0] RSTC_IDX_PACKET_END_STATE_CONTROL = 16'hdf13;
    localparam logic [15:0] RSTC_IDX_STATUS = 16'hdf20;
    localparam logic [31:0] RSTC_ADDR_RX_TIMEOUT_CONTROL = {14'h0000, RSTC_IDX_RX_TIMEOUT_CONTROL, 2'h0};
    localparam logic [31:0] RSTC_ADDR_PACKET_END_STATE_CONTROL = {14'h0000, RSTC_IDX_PACKET_END_STATE_CONTROL, 2'h0};
    localparam logic [31:0] RSTC_ADDR_STATUS = {14'h0000, RSTC_IDX_STATUS, 2'h0};

    // Field positions, rx timeout control
    localparam int RSTC_POS_RX_END_ON_SIGNAL_STRENGTH = 4;
    localparam int RSTC_POS_RX_TIMEOUT_QUALITY_CHECK = 3;
    localparam int RSTC_POS_RX_TIMEOUT_CODE = 0;
    // Field positions, packet end state control
    localparam int RSTC_POS_CLEAR_CHANNEL_POLICY = 4;
    localparam int RSTC_POS_AFTER_RECEIVE_NEXT_STATE = 2;
    localparam int RSTC_POS_AFTER_TRANSMIT_NEXT_STATE = 0;
    // Field positions, status
    localparam int RSTC_POS_ST_TIMER_RUNNING = 0;
    localparam int RSTC_POS_ST_TIMEOUT_SEEN = 1;
    localparam int RSTC_POS_ST_CHANNEL_CLEAR = 2;
    localparam int RSTC_POS_ST_CONFIG_CONFLICT = 3;

    // Values after reset
    localparam logic RSTC_RST_RX_END_ON_SIGNAL_STRENGTH = 1'h0;
    localparam logic RSTC_RST_RX_TIMEOUT_QUALITY_CHECK = 1'h0;
    localparam logic [2:0] RSTC_RST_RX_TIMEOUT_CODE = 3'h7;
    localparam logic [1:0] RSTC_RST_CLEAR_CHANNEL_POLICY = 2'h3;
    localparam logic [1:0] RSTC_RST_AFTER_RECEIVE_NEXT_STATE = 2'h0;
    localparam logic [1:0] RSTC_RST_AFTER_TRANSMIT_NEXT_STATE = 2'h0;

    // Timeout arithmetic: C*26 = 93.75*(1+4*res)/2^code, kept as 375/4 in ref periods
    localparam logic [2:0] RSTC_TIMEOUT_CODE_DISABLED = 3'h7;
    localparam logic [8:0] RSTC_TIMEOUT_SCALE_NUM = 9'h177;
    localparam int RSTC_TIMEOUT_SCALE_SHIFT = 2;

    // AXI responses
    localparam logic [1:0] RSTC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RSTC_RESP_SLVERR = 2'h2;

    // Radio states; codes equal the post-receive and post-transmit field values
    typedef enum logic [1:0] {
        RSTC_ST_IDLE = 2'b00,
        RSTC_ST_SYNTH_READY_FOR_TRANSMIT = 2'b01,
        RSTC_ST_TRANSMIT = 2'b10,
        RSTC_ST_RECEIVE = 2'b11
    } rstc_radio_state_t;

    // Status from the radio state machine, same clock
    typedef struct packed {
        logic rx_active;
        logic sync_found;
        logic preamble_quality_reached;
        logic carrier_sense;
        logic packet_receiving;
        logic packet_received;
        logic packet_sent;
        logic ref_tick;
        logic [1:0] wake_resolution_select;
        logic [15:0] wake_event_period;
    } rstc_radio_in_t;
endpackage : rstc_pkg
`default_nettype wire

//--- testbench/radio_state_transition_config_bench.sv
// Self-checking bench for the radio state transition configuration block.
// Assumes AXI4-Lite timing as handed over and radio inputs on the same clock.
`default_nettype none
module radio_state_transition_config_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rstc_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rx_to, rx_term, cc_flag, nxt_v;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb = 4'hf;
    rstc_radio_in_t radio = '0;
    rstc_radio_state_t nxt;
    int failures = 0;
    int tests_run = 0;

    // Clock at 50 MHz
    always #10 sys_clk = ~sys_clk;

    rstc_top DUT (
        .SYS_CLK_IN(sys_clk), .RESET_IN(reset),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
        .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
        .RADIO_IN(radio), .RX_TIMEOUT_OUT(rx_to), .RX_TERMINATE_OUT(rx_term),
        .CHANNEL_CLEAR_FLAG_OUT(cc_flag), .NEXT_STATE_OUT(nxt), .NEXT_STATE_VALID_OUT(nxt_v)
    );

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    // One AXI write, waits for the response
    task automatic axi_write(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] exp_resp);
        int n;
        n = 0;
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 1'b0;
        check("bvalid", bvalid, 1'b1);
        check("bresp", bresp, exp_resp);
        // Let an edge pass so a following call never re-raises bready in this step
        @(posedge sys_clk);
    endtask : axi_write

    // One AXI read, compares data and response
    task automatic axi_read(input logic [31:0] addr, input logic [31:0] exp, input logic [1:0] exp_resp);
        int n;
        n = 0;
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 1'b0;
        check("rdata", rdata, exp);
        check("rresp", rresp, exp_resp);
        // Let an edge pass so a following call never re-raises rready in this step
        @(posedge sys_clk);
    endtask : axi_read

    // End-of-packet pulse, then next state
    task automatic pulse(input logic rcv, input logic [1:0] exp);
        if (rcv) radio.packet_received <= 1'b1;
        else radio.packet_sent <= 1'b1;
        @(posedge sys_clk);
        radio.packet_received <= 1'b0;
        radio.packet_sent <= 1'b0;
        @(posedge sys_clk);
        check("next_valid", nxt_v, 1'b1);
        check("next_state", nxt, exp);
    endtask : pulse

    // One receive period; timeout window counted from entry
    task automatic rx_run(input int lo, input int hi, input logic exp_to, input logic exp_term, input int len);
        int tn, rn, rc;
        tn = -1;
        rn = -1;
        rc = 0;
        radio.rx_active <= 1'b1;
        for (int i = 1; i <= len; i++) begin
            @(posedge sys_clk);
            if (rx_to === 1'b1 && tn < 0) tn = i;
            if (rx_term === 1'b1) begin
                rc++;
                if (rn < 0) rn = i;
            end
        end
        radio.rx_active <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("timeout_seen", tn >= 0, exp_to);
        if (exp_to) check("timeout_time", tn >= lo && tn <= hi, 1'b1);
        check("term_seen", rn >= 0, exp_term);
        check("term_once", rc <= 1, 1'b1);
    endtask : rx_run

    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic [1:0] p;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        axi_read(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h07, RSTC_RESP_OKAY);
        axi_read(RSTC_ADDR_PACKET_END_STATE_CONTROL, 32'h30, RSTC_RESP_OKAY);
        axi_write(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'hffffffff, RSTC_RESP_OKAY);
        axi_read(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h1f, RSTC_RESP_OKAY);
        // Lane 0 strobe low: write answered but nothing stored
        wstrb <= 4'he;
        axi_write(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h00, RSTC_RESP_OKAY);
        wstrb <= 4'hf;
        axi_read(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h1f, RSTC_RESP_OKAY);
        axi_write(RSTC_ADDR_PACKET_END_STATE_CONTROL, 32'hffffffff, RSTC_RESP_OKAY);
        axi_read(RSTC_ADDR_PACKET_END_STATE_CONTROL, 32'h3f, RSTC_RESP_OKAY);
        axi_write(32'h00000010, 32'h5a, RSTC_RESP_SLVERR);
        axi_read(32'h00000010, 32'h0, RSTC_RESP_SLVERR);
        // Every next-state code, policy kept at always-clear
        for (int i = 0; i < 4; i++) begin
            axi_write(RSTC_ADDR_PACKET_END_STATE_CONTROL, {28'h0, i[1:0], ~i[1:0]}, RSTC_RESP_OKAY);
            pulse(1'b1, i[1:0]);
            pulse(1'b0, ~i[1:0]);
        end
        // Every clear-channel policy against both inputs
        for (int i = 0; i < 4; i++) begin
            axi_write(RSTC_ADDR_PACKET_END_STATE_CONTROL, {26'h0, i[1:0], 4'h0}, RSTC_RESP_OKAY);
            for (int c = 0; c < 4; c++) begin
                p = i[1:0];
                radio.carrier_sense <= c[0];
                radio.packet_receiving <= c[1];
                repeat (2) @(posedge sys_clk);
                check("channel_clear", cc_flag, (p[0] ? !c[0] : 1'b1) && (p[1] ? !c[1] : 1'b1));
            end
        end
        // Post-receive synth-ready with assessment on is flagged in status, channel busy
        axi_write(RSTC_ADDR_PACKET_END_STATE_CONTROL, 32'h34, RSTC_RESP_OKAY);
        axi_read(RSTC_ADDR_STATUS, 32'h08, RSTC_RESP_OKAY);
        radio.packet_receiving <= 1'b0;
        radio.ref_tick <= 1'b1;
        radio.wake_event_period <= 16'h0040;
        radio.carrier_sense <= 1'b1;
        // Code 6, resolution 0: 64*93.75/64 = 93.75, so 94 reference periods
        axi_write(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h06, RSTC_RESP_OKAY);
        rx_run(92, 98, 1'b1, 1'b1, 120);
        rx_run(92, 98, 1'b1, 1'b1, 120);
        radio.sync_found <= 1'b1;
        rx_run(92, 98, 1'b1, 1'b0, 120);
        radio.sync_found <= 1'b0;
        radio.preamble_quality_reached <= 1'b1;
        rx_run(92, 98, 1'b1, 1'b1, 120);
        axi_write(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h0e, RSTC_RESP_OKAY);
        rx_run(92, 98, 1'b1, 1'b0, 120);
        // Code 5, resolution 1: 64*5*93.75/32 = 937.5, so 938 periods
        radio.wake_resolution_select <= 2'h1;
        axi_write(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h0d, RSTC_RESP_OKAY);
        rx_run(936, 942, 1'b1, 1'b0, 960);
        radio.preamble_quality_reached <= 1'b0;
        radio.carrier_sense <= 1'b0;
        axi_write(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h07, RSTC_RESP_OKAY);
        rx_run(0, 0, 1'b0, 1'b0, 300);
        axi_write(RSTC_ADDR_RX_TIMEOUT_CONTROL, 32'h17, RSTC_RESP_OKAY);
        rx_run(0, 0, 1'b0, 1'b1, 20);
        report_and_stop();
    end
endmodule : radio_state_transition_config_bench
`default_nettype wire
